//--- src/bst_tap.sv
// Boundary-scan test access port oversampling the test clock with the system clock.
// ============================================================================
module bst_tap
  import bst_pkg::*;
#(
  parameter logic [BST_DR_W-1:0] IDCODE = BST_IDCODE_DEFAULT
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic trst_n_i,
  output logic tdo_o,
  output logic tdo_oe_n_o,
  output logic tap_reset_o,
  output logic [BST_IR_W-1:0] instr_o
);

  // ==========================================================================
  // Pin synchronisation and edge detection
  // ==========================================================================
  bst_pins_t pins_raw;
  bst_pins_t pins_s;
  logic tck_prev_reg;
  logic rise_w;
  logic fall_w;

  assign pins_raw = '{trst_n: trst_n_i, tck: tck_i, tms: tms_i, tdi: tdi_i};

  // The reset value of the synchroniser mirrors an unused port.
  bst_sync #(
    .WIDTH(BST_PINS_W),
    .INIT(BST_PINS_IDLE)
  ) u_sync (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .async_i(pins_raw),
    .sync_o(pins_s)
  );

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      tck_prev_reg <= 1'b0;
    end else if (clk_en_i) begin
      tck_prev_reg <= pins_s.tck;
    end
  end

  // TMS and TDI travel in the same synchroniser as TCK, so the values seen
  // at a detected rise are those present at the pin edge.
  assign rise_w = clk_en_i && pins_s.tck && !tck_prev_reg;
  assign fall_w = clk_en_i && !pins_s.tck && tck_prev_reg;

  // ==========================================================================
  // Controller state machine
  // ==========================================================================
  function automatic bst_state_t tap_step(input bst_state_t s, input logic tms);
    bst_state_t n;
    n = s;
    unique case (s)
      ST_RESET:      n = tms ? ST_RESET : ST_IDLE;
      ST_IDLE:       n = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR:     n = tms ? ST_SEL_IR : ST_CAPTURE_DR;
      ST_CAPTURE_DR: n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR:   n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR:   n = tms ? ST_UPDATE_DR : ST_PAUSE_DR;
      ST_PAUSE_DR:   n = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR:   n = tms ? ST_UPDATE_DR : ST_SHIFT_DR;
      ST_UPDATE_DR:  n = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR:     n = tms ? ST_RESET : ST_CAPTURE_IR;
      ST_CAPTURE_IR: n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR:   n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR:   n = tms ? ST_UPDATE_IR : ST_PAUSE_IR;
      ST_PAUSE_IR:   n = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR:   n = tms ? ST_UPDATE_IR : ST_SHIFT_IR;
      ST_UPDATE_IR:  n = tms ? ST_SEL_DR : ST_IDLE;
    endcase
    return n;
  endfunction

  bst_state_t state_reg;
  bst_state_t state_next;
  logic port_rst_w;

  assign port_rst_w = !pins_s.trst_n;
  assign state_next = tap_step(state_reg, pins_s.tms);

  // Between test clock rises only the test reset or the system reset moves the state, so a stopped clock keeps it.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_RESET;
    end else if (clk_en_i && port_rst_w) begin
      state_reg <= ST_RESET;
    end else if (rise_w) begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // Instruction and data registers
  // ==========================================================================
  logic [BST_IR_W-1:0] ir_sh_reg;
  logic [BST_IR_W-1:0] ir_reg;
  logic [BST_DR_W-1:0] dr_reg;
  logic bypass_w;
  logic in_reset_w;

  assign bypass_w = (ir_reg != BST_INSTR_IDCODE);
  // Entering reset through mode select clears the registers on that same rise.
  // Otherwise they would move a cycle later while the test clock stands still.
  assign in_reset_w = port_rst_w || (state_reg == ST_RESET) ||
                      (rise_w && state_next == ST_RESET);

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ir_reg <= BST_INSTR_IDCODE;
      ir_sh_reg <= BST_IR_CAPTURE;
    end else if (clk_en_i && in_reset_w) begin
      ir_reg <= BST_INSTR_IDCODE;
      ir_sh_reg <= BST_IR_CAPTURE;
    end else if (rise_w) begin
      unique case (state_reg)
        ST_CAPTURE_IR: ir_sh_reg <= BST_IR_CAPTURE;
        ST_SHIFT_IR:   ir_sh_reg <= {pins_s.tdi, ir_sh_reg[BST_IR_W-1:1]};
        ST_UPDATE_IR:  ir_reg <= ir_sh_reg;
        default:       ir_sh_reg <= ir_sh_reg;
      endcase
    end
  end

  // Unknown instructions select the one-bit bypass path.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      dr_reg <= '0;
    end else if (clk_en_i && in_reset_w) begin
      dr_reg <= '0;
    end else if (rise_w && state_reg == ST_CAPTURE_DR) begin
      dr_reg <= bypass_w ? '0 : IDCODE;
    end else if (rise_w && state_reg == ST_SHIFT_DR) begin
      if (bypass_w) begin
        dr_reg <= {{(BST_DR_W-1){1'b0}}, pins_s.tdi};
      end else begin
        dr_reg <= {pins_s.tdi, dr_reg[BST_DR_W-1:1]};
      end
    end
  end

  // ==========================================================================
  // Serial output, launched on the falling edge
  // ==========================================================================
  logic shifting_w;
  logic tdo_reg;
  logic tdo_oe_n_reg;

  assign shifting_w = (state_reg == ST_SHIFT_DR) || (state_reg == ST_SHIFT_IR);

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      tdo_reg <= 1'b0;
      tdo_oe_n_reg <= 1'b1;
    end else if (clk_en_i && port_rst_w) begin
      tdo_oe_n_reg <= 1'b1;
    end else if (fall_w) begin
      tdo_reg <= (state_reg == ST_SHIFT_IR) ? ir_sh_reg[0] : dr_reg[0];
      tdo_oe_n_reg <= !shifting_w;
    end
  end

  assign tdo_o = tdo_reg;
  assign tdo_oe_n_o = tdo_oe_n_reg;
  assign tap_reset_o = (state_reg == ST_RESET);
  assign instr_o = ir_reg;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence s_update_ir;
    rise_w && !port_rst_w && state_reg == ST_UPDATE_IR;
  endsequence

  sequence s_trst_low;
    clk_en_i && !pins_s.trst_n;
  endsequence

  property p_trst_reset;
    @(posedge clock_i) disable iff (sys_rst_i)
    s_trst_low |=> (state_reg == ST_RESET) && (ir_reg == BST_INSTR_IDCODE) && tdo_oe_n_reg;
  endproperty
  a_trst_reset: assert property (p_trst_reset) else $error("test reset did not reset port");

  property p_tdi_sampled;
    @(posedge clock_i) disable iff (sys_rst_i)
    rise_w && pins_s.trst_n && state_reg == ST_SHIFT_IR |=>
      ir_sh_reg[BST_IR_W-1] == $past(pins_s.tdi);
  endproperty
  a_tdi_sampled: assert property (p_tdi_sampled) else $error("data input not taken on rise");

  property p_update_ir;
    @(posedge clock_i) disable iff (sys_rst_i)
    s_update_ir |=> ir_reg == $past(ir_sh_reg);
  endproperty
  a_update_ir: assert property (p_update_ir) else $error("instruction not updated");

  property p_tdo_on_fall;
    @(posedge clock_i) disable iff (sys_rst_i)
    $changed(tdo_reg) |-> $past(fall_w);
  endproperty
  a_tdo_on_fall: assert property (p_tdo_on_fall) else $error("data output moved off a fall");

  property p_hold_state;
    @(posedge clock_i) disable iff (sys_rst_i)
    !rise_w && !fall_w && pins_s.trst_n ##1 !rise_w && !fall_w && pins_s.trst_n |->
      $stable(state_reg) && $stable(dr_reg) && $stable(ir_reg) && $stable(tdo_reg);
  endproperty
  a_hold_state: assert property (p_hold_state) else $error("state moved without clock edge");

  property p_hiz_idle;
    @(posedge clock_i) disable iff (sys_rst_i)
    fall_w && !shifting_w |=> tdo_oe_n_reg [*1] ##0 tdo_oe_n_o;
  endproperty
  a_hiz_idle: assert property (p_hiz_idle) else $error("data output driven outside shift");

  property p_drive_shift;
    @(posedge clock_i) disable iff (sys_rst_i)
    fall_w && shifting_w && pins_s.trst_n |=> !tdo_oe_n_reg;
  endproperty
  a_drive_shift: assert property (p_drive_shift) else $error("data output not driven in shift");

  property p_tms_high_holds_reset;
    @(posedge clock_i) disable iff (sys_rst_i)
    rise_w && pins_s.tms && state_reg == ST_RESET |=> state_reg == ST_RESET;
  endproperty
  a_tms_high_holds_reset: assert property (p_tms_high_holds_reset) else $error("left reset");

endmodule

//--- src/bst_pkg.sv
// Package with the encodings, reset values and pin bundle of the boundary-scan test port.
package bst_pkg;

  // ==========================================================================
  // Widths and instruction codes
  // ==========================================================================
  localparam int BST_IR_W = 4;
  localparam int BST_DR_W = 32;
  localparam logic [BST_IR_W-1:0] BST_INSTR_IDCODE = 4'h1;
  localparam logic [BST_IR_W-1:0] BST_INSTR_BYPASS = 4'hF;
  // Fixed pattern loaded into the instruction shifter when it captures.
  localparam logic [BST_IR_W-1:0] BST_IR_CAPTURE = 4'h1;
  // Identification word; the value is arbitrary. Bit 0 must stay one.
  localparam logic [BST_DR_W-1:0] BST_IDCODE_DEFAULT = 32'h0A5C_3E01;
  localparam int BST_SYNC_STAGES = 2;

  // ==========================================================================
  // Controller states
  // ==========================================================================
  typedef enum logic [3:0] {
    ST_RESET      = 4'h0,
    ST_IDLE       = 4'h1,
    ST_SEL_DR     = 4'h2,
    ST_CAPTURE_DR = 4'h3,
    ST_SHIFT_DR   = 4'h4,
    ST_EXIT1_DR   = 4'h5,
    ST_PAUSE_DR   = 4'h6,
    ST_EXIT2_DR   = 4'h7,
    ST_UPDATE_DR  = 4'h8,
    ST_SEL_IR     = 4'h9,
    ST_CAPTURE_IR = 4'hA,
    ST_SHIFT_IR   = 4'hB,
    ST_EXIT1_IR   = 4'hC,
    ST_PAUSE_IR   = 4'hD,
    ST_EXIT2_IR   = 4'hE,
    ST_UPDATE_IR  = 4'hF
  } bst_state_t;

  // ==========================================================================
  // Pin bundle from the external test controller
  // ==========================================================================
  typedef struct packed {
    logic trst_n;
    logic tck;
    logic tms;
    logic tdi;
  } bst_pins_t;

  localparam int BST_PINS_W = 4;
  // Value the synchroniser holds under reset: port in reset, TMS and TDI high.
  localparam bst_pins_t BST_PINS_IDLE = '{trst_n: 1'b0, tck: 1'b0, tms: 1'b1, tdi: 1'b1};

endpackage

//--- src/bst_sync.sv
// Two-stage synchroniser for the test port pins, frozen by the clock enable.
module bst_sync
  import bst_pkg::*;
#(
  parameter int WIDTH = BST_PINS_W,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // The first stage feeds only the second one.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      meta_reg <= INIT;
      sync_reg <= INIT;
    end else if (clk_en_i) begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule

//--- bench/bst_ctrl_model.sv
// Behavioural model of the external boundary-scan test controller.
module bst_ctrl_model (
  input wire logic clock_i,
  input wire logic tdo_i,
  output logic trst_n_o,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Pins start as if left open.
  // ==========================================================================
  initial begin
    trst_n_o = 1'b0;
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end

  // One test clock period of eight system clocks; TMS and TDI settle well before the rise.
  // Called on a falling system clock edge, so the test clock period is 320 ns.
  task automatic cycle(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    repeat (4) @(negedge clock_i);
    tck_o = 1'b1;
    tdo = tdo_i;
    repeat (4) @(negedge clock_i);
    tck_o = 1'b0;
  endtask

  task automatic set_trst(input logic v);
    @(negedge clock_i);
    tms_o = 1'b1;
    trst_n_o = v;
  endtask

  task automatic release_port();
    @(negedge clock_i);
    trst_n_o = 1'b0;
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  endtask
endmodule

//--- bench/boundary_scan_test_port_test.sv
// Self-checking testbench of the boundary-scan test port.
module boundary_scan_test_port_test;
  import bst_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic clk_en_i = 1'b1;
  wire trst_n, tck, tms, tdi;
  logic tdo_o, tdo_oe_n_o, tap_reset_o;
  logic [BST_IR_W-1:0] instr_o;
  // Nobody else drives the output wire, so it floats when the port lets go.
  wire tdo_w = tdo_oe_n_o ? 1'hZ : tdo_o;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;

  bst_tap dut_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .tck_i(tck),
    .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n), .tdo_o(tdo_o), .tdo_oe_n_o(tdo_oe_n_o),
    .tap_reset_o(tap_reset_o), .instr_o(instr_o));
  bst_ctrl_model ctrl_u (.clock_i(clock_i), .tdo_i(tdo_w), .trst_n_o(trst_n), .tck_o(tck),
    .tms_o(tms), .tdi_o(tdi));

  always #20 clock_i = ~clock_i;

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      $display("Error timeout expected %0d seen %0d", 0, cyc);
      err_total = err_total + 1;
      end_of_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic walk(input logic [7:0] bits, input int n);
    logic d;
    for (int i = 0; i < n; i++) ctrl_u.cycle(bits[i], 1'b1, d);
  endtask

  task automatic shift(input int n, input logic [31:0] din, input logic ex,
                       output logic [31:0] dout);
    logic b;
    dout = '0;
    for (int i = 0; i < n; i++) begin
      ctrl_u.cycle(ex && i == n - 1, din[i], b);
      dout[i] = b;
    end
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic test_reset();
    chk("tap_reset", 32'h1, {31'h0, tap_reset_o});
    chk("instr", 32'h1, {28'h0, instr_o});
    chk("tdo wire", {31'h0, 1'hZ}, {31'h0, tdo_w});
    $display("test_reset done");
  endtask

  // The clock stops in mid-word with the enable dropped, and the word must survive.
  task automatic test_idcode();
    logic [31:0] lo, hi;
    walk(8'h02, 4);
    shift(16, 32'h0, 1'b0, lo);
    repeat (100) @(negedge clock_i);
    clk_en_i = 1'b0;
    repeat (20) @(negedge clock_i);
    clk_en_i = 1'b1;
    repeat (100) @(negedge clock_i);
    chk("oe_n held", 32'h0, {31'h0, tdo_oe_n_o});
    shift(16, 32'h0, 1'b1, hi);
    chk("idcode", BST_IDCODE_DEFAULT, {hi[15:0], lo[15:0]});
    repeat (5) @(negedge clock_i);
    chk("tdo wire", {31'h0, 1'hZ}, {31'h0, tdo_w});
    walk(8'h01, 2);
    $display("test_idcode done");
  endtask

  task automatic test_bypass();
    logic [31:0] d;
    walk(8'h03, 4);
    shift(4, 32'hF, 1'b1, d);
    chk("ir capture", 32'h1, {28'h0, d[3:0]});
    walk(8'h01, 2);
    repeat (2) @(negedge clock_i);
    chk("instr", 32'hF, {28'h0, instr_o});
    walk(8'h01, 3);
    shift(4, 32'hD, 1'b1, d);
    chk("bypass", 32'hA, {28'h0, d[3:0]});
    walk(8'h01, 2);
    // Five rises with mode select high reach reset from idle.
    walk(8'h1F, 5);
    repeat (2) @(negedge clock_i);
    chk("tms reset", 32'h1, {31'h0, tap_reset_o});
    chk("tms instr", 32'h1, {28'h0, instr_o});
    walk(8'h00, 1);
    $display("test_bypass done");
  endtask

  task automatic test_trst();
    logic [31:0] d;
    walk(8'h01, 3);
    shift(3, 32'h0, 1'b0, d);
    repeat (5) @(negedge clock_i);
    chk("oe_n shift", 32'h0, {31'h0, tdo_oe_n_o});
    ctrl_u.set_trst(1'b0);
    repeat (6) @(negedge clock_i);
    chk("oe_n", 32'h1, {31'h0, tdo_oe_n_o});
    chk("tap_reset", 32'h1, {31'h0, tap_reset_o});
    chk("instr", 32'h1, {28'h0, instr_o});
    ctrl_u.set_trst(1'b1);
    $display("test_trst done");
  endtask

  task automatic test_open();
    walk(8'h00, 1);
    repeat (4) @(negedge clock_i);
    chk("idle", 32'h0, {31'h0, tap_reset_o});
    ctrl_u.release_port();
    repeat (40) @(negedge clock_i);
    chk("open reset", 32'h1, {31'h0, tap_reset_o});
    chk("tdo wire", {31'h0, 1'hZ}, {31'h0, tdo_w});
    $display("test_open done");
  endtask

  initial begin
    repeat (6) @(negedge clock_i);
    sys_rst_i = 1'b0;
    @(negedge clock_i);
    test_reset();
    ctrl_u.set_trst(1'b1);
    repeat (4) @(negedge clock_i);
    test_idcode();
    test_bypass();
    test_trst();
    test_open();
    end_of_test();
  end
endmodule
